/* hw/ckgen_regs.vh */
// Register offsets, field positions and reset values of the clock generator.
// Assumes a plain word-wide register port with read data one cycle later.
`ifndef CKGEN_REGS_VH
`define CKGEN_REGS_VH

`define CKGEN_SUPPLY_CONTROL_REG   4'h0
`define CKGEN_SUPPLY_MODE_REG      4'h1
`define CKGEN_OSC_CONTROL_REG      4'h2
`define CKGEN_FREQ_MEASURE_REG     4'h3
`define CKGEN_PLL_CONFIG_REG       4'h4
`define CKGEN_POWER_STATUS_REG     4'h5
`define CKGEN_POWER_IRQ_ENABLE_REG 4'h6

// osc_control_reg
`define CKGEN_MOR_FAST_RC_ENABLE   0
`define CKGEN_MOR_EXT_CLOCK_SELECT 1
// supply_control_reg / supply_mode_reg
`define CKGEN_CR_SLOW_OSC_SELECT   0
`define CKGEN_MR_CRYSTAL_BYPASS    0
// freq_measure_reg
`define CKGEN_MCFR_READY           16
// pll_config_reg: div [7:0], settle [15:8], scheme [17:16], gain [28:18]
`define CKGEN_PLL_DIV_LSB          0
`define CKGEN_PLL_CNT_LSB          8
`define CKGEN_PLL_SCH_LSB          16
`define CKGEN_PLL_MUL_LSB          18
// power_status_reg / power_irq_enable_reg
`define CKGEN_SR_PRIMARY_READY     0
`define CKGEN_SR_LOCK              1
`define CKGEN_SR_SWITCH_DONE       2

`define CKGEN_PLL_RESET            32'h0002_0000
`define CKGEN_MEAS_PERIODS         5'h10
// Primary clock ready delay in ref_clk cycles (oscillator startup model)
`define CKGEN_RC_STARTUP_CYCLES    8'h10

`endif

/* hw/ckgen_top.v */
// Clock generator control: slow/primary source selection, frequency
// measurement, PLL divider/multiplier sequencing and lock counting.
// Assumes slow_clock and ext_clock_in are asynchronous pins sampled on
// ref_clk (25 MHz), and primary clock edges are observed the same way.
//
// Functional notes
// - Slow clock source follows slow oscillator select bit.
// - Reset: slow RC runs and is selected.
// - Reset: fast RC enabled and selected as primary clock.
// - Clearing fast RC enable stops fast RC and clears ready.
// - Primary ready flag raises interrupt when enabled.
// - Measure starts after slow rise; stops at 16th slow fall.
// - Count value holds primary cycles over 15.5 slow periods.
// - Ext clock select switches primary source; done flag reports it.
// - Divider zero holds divider and PLL outputs low; resets zero.
// - PLL gain is factor plus one; factor zero disables PLL.
// - Enable or parameter change clears lock and loads settle counter.
// - Counter decrements per slow cycle; zero sets lock, may interrupt.
// - Fast scheme 0 with settle 1 reaches 70 percent in 60 us.
// - Slow clock is always running except in off mode.
// - Primary clock comes from ext input or fast RC.
//
// The register addresses and strobed register access were decided locally.
`include "ckgen_regs.vh"
`default_nettype none

module ckgen_top (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        srst,
  // Register port
  input  wire [3:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // Clock pins
  input  wire        slow_rc_in,
  input  wire        slow_xtal_in,
  input  wire        fast_rc_in,
  input  wire        ext_clock_in,
  input  wire        fast_startup,
  // Oscillator controls and selections
  output reg         slow_rc_on,
  output reg         slow_xtal_on,
  output reg         slow_sel_xtal,
  output reg         fast_rc_on,
  output reg         primary_sel_ext,
  output reg         pll_enable,
  output reg  [10:0] pll_gain_factor,
  output reg  [7:0]  pll_divider,
  output reg  [1:0]  pll_startup_scheme,
  output reg         pll_out_gate,
  output reg         irq
);

  // Input synchronisers: stage 1 read only by stage 2
  reg  [4:0] s1_q;
  reg  [4:0] s2_q;
  reg  [4:0] s3_q;
  wire [4:0] pin_in = {fast_startup, ext_clock_in, fast_rc_in,
                       slow_xtal_in, slow_rc_in};

  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1)
    begin : g_sync
      always @(posedge ref_clk)
      begin
        s1_q[g] <= pin_in[g];
        s2_q[g] <= s1_q[g];
        s3_q[g] <= s2_q[g];
      end
    end
  endgenerate

  reg         sel_xtal_q;
  reg         bypass_q;
  reg         rc_en_q;
  reg         ext_sel_q;
  reg  [31:0] pllr_q;
  reg  [2:0]  ier_q;
  reg         ready_q;
  reg         lock_q;
  reg         sw_done_q;
  reg  [7:0]  start_cnt_q;
  reg         fr_ready_q;
  reg  [15:0] fr_count_q;
  reg  [1:0]  meas_st_q;
  reg  [4:0]  falls_q;
  reg  [7:0]  pll_cnt_q;
  reg         pll_run_q;

  // Slow clock edges from the selected source
  wire slow_now  = sel_xtal_q ? s2_q[1] : s2_q[0];
  wire slow_prev = sel_xtal_q ? s3_q[1] : s3_q[0];
  wire slow_rise = slow_now & ~slow_prev;
  wire slow_fall = ~slow_now & slow_prev;
  // Primary clock comes from external pin or the fast RC
  wire prim_now  = ext_sel_q ? s2_q[3] : s2_q[2];
  wire prim_prev = ext_sel_q ? s3_q[3] : s3_q[2];
  wire prim_rise = prim_now & ~prim_prev;
  wire wake      = s2_q[4];

  wire wr_mor  = reg_wr && (reg_addr == `CKGEN_OSC_CONTROL_REG);
  wire wr_pllr = reg_wr && (reg_addr == `CKGEN_PLL_CONFIG_REG);
  wire new_en  = wr_mor & reg_wdata[`CKGEN_MOR_FAST_RC_ENABLE];
  wire rc_en_d = wake | (wr_mor ? new_en : rc_en_q);
  wire rc_rise = rc_en_d & ~rc_en_q;

  wire [10:0] new_mul = reg_wdata[`CKGEN_PLL_MUL_LSB +: 11];
  wire [7:0]  new_div = reg_wdata[`CKGEN_PLL_DIV_LSB +: 8];
  // Any change of PLL parameters with a nonzero gain factor restarts the settle count
  wire pll_restart = wr_pllr && (new_mul != 11'h000) &&
                     (reg_wdata != pllr_q);

  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_CNT  = 2'h2;
  localparam ST_DONE = 2'h3;

  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      sel_xtal_q  <= 1'b0;
      bypass_q    <= 1'b0;
      rc_en_q     <= 1'b1;
      ext_sel_q   <= 1'b0;
      pllr_q      <= `CKGEN_PLL_RESET;
      ier_q       <= 3'h0;
      ready_q     <= 1'b0;
      start_cnt_q <= `CKGEN_RC_STARTUP_CYCLES;
      sw_done_q   <= 1'b1;
      lock_q      <= 1'b0;
      pll_cnt_q   <= 8'h00;
      pll_run_q   <= 1'b0;
      fr_ready_q  <= 1'b0;
      fr_count_q  <= 16'h0000;
      meas_st_q   <= ST_WAIT;
      falls_q     <= 5'h00;
    end
    else
    begin
      if (reg_wr && (reg_addr == `CKGEN_SUPPLY_CONTROL_REG))
        sel_xtal_q <= reg_wdata[`CKGEN_CR_SLOW_OSC_SELECT];
      if (reg_wr && (reg_addr == `CKGEN_SUPPLY_MODE_REG))
        bypass_q <= reg_wdata[`CKGEN_MR_CRYSTAL_BYPASS];
      if (reg_wr && (reg_addr == `CKGEN_POWER_IRQ_ENABLE_REG))
        ier_q <= reg_wdata[2:0];

      // Fast RC enable, ready flag after startup delay
      rc_en_q <= rc_en_d;
      if (wake)
        ext_sel_q <= 1'b0;
      else if (wr_mor)
        ext_sel_q <= reg_wdata[`CKGEN_MOR_EXT_CLOCK_SELECT];
      // Source switch takes one cycle to settle
      sw_done_q <= ~(wr_mor &&
        (reg_wdata[`CKGEN_MOR_EXT_CLOCK_SELECT] != ext_sel_q));
      if (!rc_en_d)
      begin
        ready_q     <= 1'b0;
        start_cnt_q <= `CKGEN_RC_STARTUP_CYCLES;
      end
      else if (start_cnt_q != 8'h00)
        start_cnt_q <= start_cnt_q - 8'h01;
      else
        ready_q <= 1'b1;

      // Frequency measurement
      case (meas_st_q)
        ST_IDLE:
        begin
          if (rc_rise)
            meas_st_q <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (slow_rise && rc_en_q)
          begin
            meas_st_q  <= ST_CNT;
            fr_count_q <= 16'h0000;
            falls_q    <= 5'h00;
          end
        end
        ST_CNT:
        begin
          if (prim_rise && rc_en_q)
            fr_count_q <= fr_count_q + 16'h0001;
          if (slow_fall)
          begin
            falls_q <= falls_q + 5'h01;
            if (falls_q + 5'h01 == `CKGEN_MEAS_PERIODS)
            begin
              meas_st_q  <= ST_DONE;
              fr_ready_q <= 1'b1;
            end
          end
        end
        ST_DONE:
        begin
          meas_st_q <= ST_DONE;
        end
        default:
          meas_st_q <= ST_IDLE;
      endcase
      if (rc_rise)
      begin
        meas_st_q  <= ST_WAIT;
        fr_ready_q <= 1'b0;
      end

      // PLL configuration and lock counter
      if (wr_pllr)
        pllr_q <= reg_wdata;
      if (wr_pllr && (new_mul == 11'h000))
      begin
        pll_run_q <= 1'b0;
        lock_q    <= 1'b0;
      end
      else if (pll_restart)
      begin
        lock_q    <= 1'b0;
        pll_run_q <= 1'b1;
        pll_cnt_q <= reg_wdata[`CKGEN_PLL_CNT_LSB +: 8];
      end
      else if (pll_run_q && slow_rise)
      begin
        if (pll_cnt_q == 8'h00)
        begin
          lock_q    <= 1'b1;
          pll_run_q <= 1'b0;
        end
        else
          pll_cnt_q <= pll_cnt_q - 8'h01;
      end
    end
  end

  wire [10:0] cur_mul = pllr_q[`CKGEN_PLL_MUL_LSB +: 11];
  wire [2:0]  status  = {sw_done_q, lock_q, ready_q};

  // Outputs registered
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      reg_rdata          <= 32'h0000_0000;
      slow_rc_on         <= 1'b1;
      slow_xtal_on       <= 1'b0;
      slow_sel_xtal      <= 1'b0;
      fast_rc_on         <= 1'b1;
      primary_sel_ext    <= 1'b0;
      pll_enable         <= 1'b0;
      pll_gain_factor    <= 11'h000;
      pll_divider        <= 8'h00;
      pll_startup_scheme <= 2'h2;
      pll_out_gate       <= 1'b0;
      irq                <= 1'b0;
    end
    else
    begin
      // Crystal oscillator powered down in bypass mode; pin drives directly
      slow_rc_on         <= ~sel_xtal_q;
      slow_xtal_on       <= sel_xtal_q & ~bypass_q;
      slow_sel_xtal      <= sel_xtal_q;
      fast_rc_on         <= rc_en_q;
      primary_sel_ext    <= ext_sel_q;
      pll_enable         <= (cur_mul != 11'h000);
      pll_gain_factor    <= cur_mul;
      pll_divider        <= pllr_q[`CKGEN_PLL_DIV_LSB +: 8];
      pll_startup_scheme <= pllr_q[`CKGEN_PLL_SCH_LSB +: 2];
      // Zero divider or zero factor keeps PLL output low
      pll_out_gate       <= (pllr_q[`CKGEN_PLL_DIV_LSB +: 8] != 8'h00) &&
                            (cur_mul != 11'h000);
      irq                <= |(status & ier_q);
      reg_rdata          <= 32'h0000_0000;
      if (reg_rd)
      begin
        case (reg_addr)
          `CKGEN_SUPPLY_CONTROL_REG:   reg_rdata <= {31'h0, sel_xtal_q};
          `CKGEN_SUPPLY_MODE_REG:      reg_rdata <= {31'h0, bypass_q};
          `CKGEN_OSC_CONTROL_REG:
            reg_rdata <= {30'h0, ext_sel_q, rc_en_q};
          `CKGEN_FREQ_MEASURE_REG:
            reg_rdata <= {15'h0, fr_ready_q, fr_count_q};
          `CKGEN_PLL_CONFIG_REG:       reg_rdata <= pllr_q;
          `CKGEN_POWER_STATUS_REG:     reg_rdata <= {29'h0, status};
          `CKGEN_POWER_IRQ_ENABLE_REG: reg_rdata <= {29'h0, ier_q};
          default:                     reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

/* bench/ckgen_monitor.sv */
// Port checker for the clock generator control block.
// Assumes one clock domain and a synchronous active-high reset.
`default_nettype none
module ckgen_monitor (
  // Clock, reset, register writes
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        fast_startup,
  // Clock controls
  input wire logic        slow_rc_on,
  input wire logic        slow_xtal_on,
  input wire logic        slow_sel_xtal,
  input wire logic        fast_rc_on,
  input wire logic        primary_sel_ext,
  input wire logic        pll_enable,
  input wire logic [10:0] pll_gain_factor,
  input wire logic [7:0]  pll_divider,
  input wire logic        pll_out_gate,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Wake reaches the core two cycles late and overrides a write there;
  // register copies reach the pins one cycle after the register
  wire wr_osc = reg_wr && reg_addr == 4'h2;
  wire wr_pll = reg_wr && reg_addr == 4'h4;

  chk_div_zero_low: assert property (
    pll_divider == 8'h00 |-> !pll_out_gate) else $error("gate with div 0");
  chk_gate_cause: assert property (
    pll_out_gate |-> pll_enable) else $error("gate without pll");
  chk_gain_enable: assert property (
    pll_enable == (pll_gain_factor != 11'h000)) else $error("pll enable");
  chk_rc_disable: assert property (
    wr_osc && !reg_wdata[0] && !$past(fast_startup, 2) |-> ##2 !fast_rc_on)
    else $error("rc not off");
  chk_ext_switch: assert property (
    wr_osc && !$past(fast_startup, 2) |->
    ##2 primary_sel_ext == $past(reg_wdata[1], 2))
    else $error("primary source");
  chk_slow_select: assert property (
    reg_wr && reg_addr == 4'h0 |->
    ##2 slow_sel_xtal == $past(reg_wdata[0], 2)
    && slow_rc_on != slow_sel_xtal) else $error("slow source");
  chk_xtal_sel: assert property (
    slow_xtal_on |-> slow_sel_xtal) else $error("xtal unselected");
  chk_pll_copy: assert property (
    wr_pll |-> ##2 pll_divider == $past(reg_wdata[7:0], 2)
    && pll_gain_factor == $past(reg_wdata[28:18], 2))
    else $error("pll copy");
  chk_wake_rc: assert property (
    $rose(fast_startup) |-> ##[1:6] fast_rc_on && !primary_sel_ext)
    else $error("wake");
  cover property ($rose(pll_out_gate));
  cover property ($rose(irq));
  cover property ($fell(fast_rc_on));
endmodule
bind ckgen_top ckgen_monitor u_mon (.ref_clk(ref_clk), .srst(srst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .fast_startup(fast_startup), .slow_rc_on(slow_rc_on),
  .slow_xtal_on(slow_xtal_on), .slow_sel_xtal(slow_sel_xtal),
  .fast_rc_on(fast_rc_on), .primary_sel_ext(primary_sel_ext),
  .pll_enable(pll_enable), .pll_gain_factor(pll_gain_factor),
  .pll_divider(pll_divider), .pll_out_gate(pll_out_gate), .irq(irq));
`default_nettype wire

/* bench/ckgen_top_tb.sv */
// Self-checking bench for the clock generator control block.
// Assumes ckgen_top; slow pins period 20 cycles, fast RC 4 cycles.
`default_nettype none
module ckgen_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        rd_q = 1'b0;
  logic        slow_in = 1'b0;
  logic        fast_in = 1'b0;
  logic        ext_in = 1'b0;
  logic        wake = 1'b0;
  logic        fast_rc_on, sel_ext, gate, irq, pll_en, sel_x, x_on;
  logic [1:0]  scheme;
  logic [31:0] reg_rdata, rdv, seed = 32'h3385;
  logic [31:0] exp_q[$], msk_q[$];
  int          num_errors = 0, tests_run = 0, settle;

  ckgen_top uut (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .slow_rc_in(slow_in), .slow_xtal_in(slow_in),
    .fast_rc_in(fast_in), .ext_clock_in(ext_in), .fast_startup(wake),
    .slow_rc_on(), .slow_xtal_on(x_on), .slow_sel_xtal(sel_x),
    .fast_rc_on(fast_rc_on), .primary_sel_ext(sel_ext),
    .pll_enable(pll_en), .pll_gain_factor(), .pll_divider(),
    .pll_startup_scheme(scheme), .pll_out_gate(gate), .irq(irq));

  always #20 ref_clk = ~ref_clk;
  always #400 slow_in = ~slow_in;
  always #80 fast_in = ~fast_in;
  always #120 ext_in = ~ext_in;

  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Write then read with no gap, to catch one-cycle status pulses
  task wrrd(input logic [3:0] a, input logic [31:0] d, input logic [3:0] ra,
            input logic [31:0] e, input logic [31:0] m);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= ra;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask
  task stop_test;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Read data stand one cycle only
  always @(posedge ref_clk)
  begin
    if (rd_q)
    begin
      rdv = reg_rdata;
      check(reg_rdata & msk_q.pop_front(), exp_q.pop_front());
    end
    rd_q <= reg_rd;
  end

  initial
  begin
    repeat (30000) @(posedge ref_clk);
    num_errors++;
    stop_test();
  end

  initial
  begin
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    rd(4'h2, 32'h1, 32'h3);
    rd(4'h0, 32'h0, 32'h1);
    rd(4'h4, 32'h0002_0000, 32'hFFFF_FFFF);
    rd(4'h9, 32'h0, 32'hFFFF_FFFF);
    // One full measurement plus the first slow edge
    cyc(420);
    rd(4'h3, 32'h1_0000, 32'h1_0000);
    cyc(2);
    check(32'(rdv[15:0] inside {[16'h4C:16'h52]}), 32'h1);
    wr(4'h6, 32'h1);
    cyc(2);
    check(32'(irq), 32'h1);
    wr(4'h2, 32'h0);
    rd(4'h5, 32'h0, 32'h1);
    check(32'(irq), 32'h0);
    wr(4'h2, 32'h1);
    rd(4'h3, 32'h0, 32'h1_0000);
    cyc(420);
    rd(4'h3, 32'h1_0000, 32'h1_0000);
    rd(4'h5, 32'h1, 32'h1);
    seed = lfsr(seed);
    settle = seed[1:0] + 2;
    wr(4'h4, {3'h0, seed[13:3] | 11'h001, 2'h2, 8'(settle),
              8'h01});
    wr(4'h6, 32'h2);
    cyc((settle + 3) * 20);
    rd(4'h5, 32'h2, 32'h2);
    check(32'(irq), 32'h1);
    wr(4'h4, {3'h0, seed[13:3] | 11'h001, 2'h0, 8'(settle), 8'h00});
    rd(4'h5, 32'h0, 32'h2);
    check(32'(gate), 32'h0);
    check(32'(scheme), 32'h0);
    cyc((settle - 1) * 20);
    rd(4'h5, 32'h0, 32'h2);
    cyc(100);
    rd(4'h5, 32'h2, 32'h2);
    wr(4'h4, 32'h0002_0000);
    rd(4'h5, 32'h0, 32'h2);
    check(32'(pll_en), 32'h0);
    check(32'(scheme), 32'h2);
    wrrd(4'h2, 32'h3, 4'h5, 32'h0, 32'h4);
    cyc(3);
    check(32'(sel_ext), 32'h1);
    rd(4'h5, 32'h4, 32'h4);
    wr(4'h2, 32'h2);
    wake <= 1'b1;
    cyc(8);
    check({sel_ext, fast_rc_on}, 32'h1);
    @(posedge ref_clk);
    wake <= 1'b0;
    wr(4'h1, 32'h1);
    wr(4'h0, 32'h1);
    cyc(2);
    check({sel_x, x_on}, 32'h2);
    wr(4'h1, 32'h0);
    cyc(2);
    check(32'(x_on), 32'h1);
    rd(4'h0, 32'h1, 32'h1);
    cyc(4);
    stop_test();
  end
endmodule
`default_nettype wire
